/* rtl/tssx_exec.sv */
// Execution of swap, table read/write, test-skip and xor literal
`timescale 1ns/100ps
`default_nettype none
module tssx_exec (
	input  wire logic                           sys_clk,
	input  wire logic                           sys_rst,
	input  wire logic [15:0]                    instr,
	input  wire logic                           instr_valid,
	input  wire logic [1:0]                     next_words,
	input  wire logic                           ext_set_en,
	input  wire logic [3:0]                     bank_select_reg,
	input  wire logic [7:0]                     file_rdata,
	input  wire logic [7:0]                     pm_rdata,
	input  wire logic [tssx_pkg::HOLD_BITS-1:0] hold_raddr,
	output logic      [tssx_pkg::HOLD_BITS-1:0] hold_addr,
	output logic      [7:0]                     hold_rdata,
	output logic      [7:0]                     file_addr,
	output logic      [3:0]                     file_bank,
	output logic                                file_indexed,
	output tssx_pkg::tssx_fwr_s                 file_wr,
	output logic      [tssx_pkg::PTR_W-1:0]     pm_addr,
	output logic                                pm_rd,
	output logic      [tssx_pkg::PTR_W-1:0]     table_pointer,
	output logic      [7:0]                     table_latch,
	output logic      [7:0]                     wreg,
	output tssx_pkg::tssx_flags_s               flags,
	output logic                                flags_we,
	output logic                                busy,
	output tssx_pkg::tssx_phase_e               phase,
	output logic                                discard
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic [tssx_pkg::PTR_W-1:0] ptr_step(
		input logic [tssx_pkg::PTR_W-1:0] p,
		input logic [1:0]                 mode
	);
		case (mode)
			tssx_pkg::MODE_POSTINC: ptr_step = p + 21'h000001;
			tssx_pkg::MODE_PREINC:  ptr_step = p + 21'h000001;
			tssx_pkg::MODE_POSTDEC: ptr_step = p - 21'h000001;
			default:                ptr_step = p;
		endcase
	endfunction

	tssx_pkg::tssx_phase_e phase_r;
	tssx_pkg::tssx_state_e state_r;
	logic [15:0]  ir_r;
	logic [1:0]   flush_r;
	logic [tssx_pkg::PTR_W-1:0] acc_ptr_r;
	logic         is_swap;
	logic         is_skip;
	logic         is_xor;
	logic         is_trd;
	logic         is_twr;
	logic         dest_f;
	logic [7:0]   xor_res;
	logic [7:0]   swap_res;
	logic         go;

	assign go      = instr_valid && (phase_r == tssx_pkg::TSSX_Q1)
		&& (state_r == tssx_pkg::TSSX_EXEC);
	assign is_swap = (ir_r[15:10] == tssx_pkg::OPC_SWAP);
	assign is_skip = (ir_r[15:9] == tssx_pkg::OPC_TSTSZ);
	assign is_xor  = (ir_r[15:8] == tssx_pkg::OPC_XORL);
	assign is_trd  = (ir_r[15:4] == tssx_pkg::OPC_TBL) && (ir_r[3:2] == tssx_pkg::TBL_RD);
	assign is_twr  = (ir_r[15:4] == tssx_pkg::OPC_TBL) && (ir_r[3:2] == tssx_pkg::TBL_WR);
	assign dest_f  = ir_r[9];
	assign swap_res = {file_rdata[3:0], file_rdata[7:4]};
	assign xor_res  = wreg ^ ir_r[7:0];

	// ------------------------------------------------------------
	// Operand addressing
	// ------------------------------------------------------------
	always_comb begin
		file_addr    = ir_r[7:0];
		file_indexed = 1'b0;
		if (ir_r[8]) begin
			file_bank = bank_select_reg;
		end else begin
			// Access bank: low half of bank 0, high half of SFR bank
			file_bank = ir_r[7] ? tssx_pkg::ACC_SFR_BANK[3:0] : 4'h0;
			file_indexed = ext_set_en && (ir_r[7:0] <= tssx_pkg::ACC_LIMIT);
		end
	end

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_r <= tssx_pkg::TSSX_Q1;
		end else begin
			case (phase_r)
				tssx_pkg::TSSX_Q1: phase_r <= (go || state_r != tssx_pkg::TSSX_EXEC)
					? tssx_pkg::TSSX_Q2 : tssx_pkg::TSSX_Q1;
				tssx_pkg::TSSX_Q2: phase_r <= tssx_pkg::TSSX_Q3;
				tssx_pkg::TSSX_Q3: phase_r <= tssx_pkg::TSSX_Q4;
				tssx_pkg::TSSX_Q4: phase_r <= tssx_pkg::TSSX_Q1;
				default:           phase_r <= tssx_pkg::TSSX_Q1;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ir_r <= 16'h0000;
		end else if (go) begin
			ir_r <= instr;
		end
	end

	// ------------------------------------------------------------
	// Cycle state: second table cycle and skip flush
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= tssx_pkg::TSSX_EXEC;
			flush_r <= 2'h0;
		end else if (phase_r == tssx_pkg::TSSX_Q4) begin
			case (state_r)
				tssx_pkg::TSSX_EXEC: begin
					if (is_trd || is_twr) begin
						state_r <= tssx_pkg::TSSX_TBL2;
					end else if (is_skip && file_rdata == 8'h00) begin
						state_r <= tssx_pkg::TSSX_FLUSH;
						flush_r <= next_words - 2'h1;
					end
				end
				tssx_pkg::TSSX_TBL2: state_r <= tssx_pkg::TSSX_EXEC;
				tssx_pkg::TSSX_FLUSH: begin
					if (flush_r == 2'h0) begin
						state_r <= tssx_pkg::TSSX_EXEC;
					end else begin
						flush_r <= flush_r - 2'h1;
					end
				end
				default: state_r <= tssx_pkg::TSSX_EXEC;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Table pointer and latch
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			table_pointer <= tssx_pkg::PTR_RST;
			acc_ptr_r     <= tssx_pkg::PTR_RST;
		end else if (phase_r == tssx_pkg::TSSX_Q4 && state_r == tssx_pkg::TSSX_EXEC
			&& (is_trd || is_twr)) begin
			// Pre-increment moves first, so access uses the new value
			acc_ptr_r <= (ir_r[1:0] == tssx_pkg::MODE_PREINC)
				? ptr_step(table_pointer, ir_r[1:0]) : table_pointer;
			table_pointer <= ptr_step(table_pointer, ir_r[1:0]);
		end
	end

	assign pm_addr = acc_ptr_r;
	assign pm_rd   = (state_r == tssx_pkg::TSSX_TBL2) && is_trd
		&& (phase_r == tssx_pkg::TSSX_Q2);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			table_latch <= tssx_pkg::LATCH_RST;
		end else if (state_r == tssx_pkg::TSSX_TBL2 && is_trd
			&& phase_r == tssx_pkg::TSSX_Q4) begin
			table_latch <= pm_rdata;
		end
	end

	// ------------------------------------------------------------
	// Holding registers
	// ------------------------------------------------------------
	logic hold_we;
	assign hold_we   = (state_r == tssx_pkg::TSSX_TBL2) && is_twr
		&& (phase_r == tssx_pkg::TSSX_Q4);
	assign hold_addr = acc_ptr_r[tssx_pkg::HOLD_BITS-1:0];

	tssx_hold_mem u_hold (
		.sys_clk (sys_clk),
		.we      (hold_we),
		.waddr   (hold_addr),
		.wdata   (table_latch),
		.raddr   (hold_raddr),
		.rdata   (hold_rdata)
	);

	// ------------------------------------------------------------
	// Results, W and flags
	// ------------------------------------------------------------
	logic wb;
	assign wb = (phase_r == tssx_pkg::TSSX_Q4) && (state_r == tssx_pkg::TSSX_EXEC);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wreg <= tssx_pkg::W_RST;
		end else if (wb && is_xor) begin
			wreg <= xor_res;
		end else if (wb && is_swap && !dest_f) begin
			wreg <= swap_res;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags    <= '0;
			flags_we <= 1'b0;
		end else begin
			flags_we <= wb && is_xor;
			if (wb && is_xor) begin
				flags.zero <= (xor_res == 8'h00);
				flags.neg  <= xor_res[7];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			file_wr <= '0;
		end else begin
			file_wr.we      <= wb && is_swap && dest_f;
			file_wr.addr    <= file_addr;
			file_wr.bank    <= file_bank;
			file_wr.indexed <= file_indexed;
			file_wr.data    <= swap_res;
		end
	end

	assign busy    = (state_r != tssx_pkg::TSSX_EXEC) || (phase_r != tssx_pkg::TSSX_Q1);
	assign phase   = phase_r;
	assign discard = (state_r == tssx_pkg::TSSX_FLUSH);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_xor_done;
		wb && is_xor;
	endsequence

	a_xor_result: assert property (s_xor_done |=> wreg == $past(xor_res))
		else $error("xor result wrong");
	a_xor_flags: assert property (s_xor_done |=> flags.zero == (wreg == 8'h00)
		&& flags.neg == wreg[7] && flags_we)
		else $error("xor flags wrong");
	a_flags_only_xor: assert property (flags_we |-> $past(is_xor))
		else $error("flags written by other op");
	a_flags_hold: assert property (!$past(wb && is_xor) |-> $stable(flags))
		else $error("flags changed");
	a_swap_file: assert property (file_wr.we |-> file_wr.data
		== {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
		else $error("swap data wrong");
	a_swap_dest: assert property (wb && is_swap |=> file_wr.we == $past(dest_f))
		else $error("swap destination wrong");
	a_index_mode: assert property (file_indexed |-> !ir_r[8] && ir_r[7:0] <= 8'h5f)
		else $error("indexed mode wrong");
	a_trd_two: assert property (wb && is_trd |=> state_r == tssx_pkg::TSSX_TBL2 [*4]
		##1 state_r == tssx_pkg::TSSX_EXEC)
		else $error("table read length wrong");
	a_skip_nz: assert property (wb && is_skip && file_rdata != 8'h00
		|=> state_r == tssx_pkg::TSSX_EXEC)
		else $error("skip without zero");
	a_postinc: assert property (wb && (is_trd || is_twr) && ir_r[1:0] == 2'h1
		|=> table_pointer == $past(table_pointer) + 21'h000001
		&& acc_ptr_r == $past(table_pointer))
		else $error("post increment wrong");

endmodule
`default_nettype wire

/* common/tssx_pkg.sv */
// Package for the table/swap/skip/xor execution block
package tssx_pkg;

	localparam int PTR_W      = 21;
	localparam int HOLD_BITS  = 7;
	localparam int HOLD_DEPTH = 128;
	localparam logic [7:0] ACC_LIMIT = 8'h5f;
	localparam logic [7:0] ACC_SFR_BANK = 8'hff;
	localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] W_RST = 8'h00;

	localparam logic [5:0]  OPC_SWAP  = 6'h0e;
	localparam logic [6:0]  OPC_TSTSZ = 7'h33;
	localparam logic [7:0]  OPC_XORL  = 8'h0a;
	localparam logic [11:0] OPC_TBL   = 12'h000;
	localparam logic [1:0]  TBL_RD    = 2'h2;
	localparam logic [1:0]  TBL_WR    = 2'h3;

	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_POSTINC = 2'h1;
	localparam logic [1:0] MODE_POSTDEC = 2'h2;
	localparam logic [1:0] MODE_PREINC = 2'h3;

	typedef enum logic [1:0] {
		TSSX_Q1 = 2'h0,
		TSSX_Q2 = 2'h1,
		TSSX_Q3 = 2'h3,
		TSSX_Q4 = 2'h2
	} tssx_phase_e;

	typedef enum logic [1:0] {
		TSSX_EXEC  = 2'h0,
		TSSX_TBL2  = 2'h1,
		TSSX_FLUSH = 2'h3
	} tssx_state_e;

	typedef struct packed {
		logic       neg;
		logic       zero;
	} tssx_flags_s;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [3:0] bank;
		logic       indexed;
		logic [7:0] data;
	} tssx_fwr_s;

endpackage

/* rtl/tssx_hold_mem.sv */
// Holding register store for pending flash programming data
`timescale 1ns/100ps
`default_nettype none
module tssx_hold_mem (
	input  wire logic                            sys_clk,
	input  wire logic                            we,
	input  wire logic [tssx_pkg::HOLD_BITS-1:0]  waddr,
	input  wire logic [7:0]                      wdata,
	input  wire logic [tssx_pkg::HOLD_BITS-1:0]  raddr,
	output logic      [7:0]                      rdata
);

	logic [7:0] mem [tssx_pkg::HOLD_DEPTH];

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule
`default_nettype wire

/* verif/tssx_pm_model.sv */
// Program memory model answering table reads of the execution block
`timescale 1ns/100ps
`default_nettype none
module tssx_pm_model (
	input  wire logic                       sys_clk,
	input  wire logic [tssx_pkg::PTR_W-1:0] pm_addr,
	input  wire logic                       pm_rd,
	output logic      [7:0]                 pm_rdata
);
	logic [7:0] q_r;
	logic [1:0] hold_r = 2'h0;
	// Content is a function of the byte address; bit 0 picks the word half
	always_ff @(posedge sys_clk) begin
		if (pm_rd) begin
			q_r <= pm_addr[8:1] ^ pm_addr[20:13] ^ (pm_addr[0] ? 8'h3c : 8'ha5);
			hold_r <= 2'h3;
		end else if (hold_r != 2'h0) begin
			hold_r <= hold_r - 2'h1;
		end
	end
	// Outside the read window the bus shows junk, never the last byte
	assign pm_rdata = (hold_r != 2'h0) ? q_r : ~q_r;
endmodule
`default_nettype wire

/* verif/tssx_exec_test.sv */
// Self-checking bench for the execution block
`timescale 1ns/100ps
`default_nettype none
module tssx_exec_test;
	logic                  sys_clk = 1'b0;
	logic                  sys_rst = 1'b1;
	logic [15:0]           instr = 16'h0000;
	logic                  instr_valid = 1'b0;
	logic [1:0]            next_words = 2'h1;
	logic                  ext_set_en = 1'b0;
	logic [3:0]            bank_select_reg = 4'h5;
	logic [7:0]            file_rdata = 8'h00;
	logic [6:0]            hold_raddr = 7'h00;
	logic [7:0]            pm_rdata, hold_rdata, file_addr, table_latch, wreg, fa;
	logic [6:0]            hold_addr;
	logic [3:0]            file_bank, fb;
	logic [20:0]           pm_addr, table_pointer, p = 21'h0, ea;
	logic                  file_indexed, pm_rd, flags_we, busy, discard, fi, fwe, wwe, dsc;
	tssx_pkg::tssx_fwr_s   file_wr, fw;
	tssx_pkg::tssx_flags_s flags;
	tssx_pkg::tssx_phase_e phase;
	int                    err_count = 0;
	int                    n_checks = 0;
	int                    ncyc;

	always #50 sys_clk = ~sys_clk;

	tssx_exec dut (.sys_clk, .sys_rst, .instr, .instr_valid, .next_words, .ext_set_en,
		.bank_select_reg, .file_rdata, .pm_rdata, .hold_raddr, .hold_addr, .hold_rdata,
		.file_addr, .file_bank, .file_indexed, .file_wr, .pm_addr, .pm_rd, .table_pointer,
		.table_latch, .wreg, .flags, .flags_we, .busy, .phase, .discard);
	tssx_pm_model pm (.sys_clk, .pm_addr, .pm_rd, .pm_rdata);

	function automatic logic [7:0] pmb(input logic [20:0] a);
		return a[8:1] ^ a[20:13] ^ (a[0] ? 8'h3c : 8'ha5);
	endfunction

	task wrap_up;
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (exp !== got) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Issue one word, then follow it until the block is idle again
	task run(input logic [15:0] op);
		@(negedge sys_clk);
		instr = op;
		instr_valid = 1'b1;
		@(negedge sys_clk);
		instr_valid = 1'b0;
		ncyc = 1;
		fa = file_addr;
		fb = file_bank;
		fi = file_indexed;
		fwe = flags_we;
		dsc = discard;
		wwe = 1'b0;
		fw = file_wr;
		while (busy !== 1'b0) begin
			if (ncyc > 40) begin
				chk("busy", 0, 1);
				wrap_up();
			end
			@(negedge sys_clk);
			ncyc++;
			fwe |= flags_we;
			dsc |= discard;
			if (file_wr.we === 1'b1) begin
				wwe = 1'b1;
				fw = file_wr;
			end
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_xor;
		run({tssx_pkg::OPC_XORL, 8'h80});
		chk("xor_cycles", 4, ncyc);
		chk("wreg", 8'h80, wreg);
		chk("flags", 2'h2, flags);
		chk("flags_we", 1, fwe);
		run({tssx_pkg::OPC_XORL, 8'h80});
		chk("wreg", 8'h00, wreg);
		chk("flags", 2'h1, flags);
		chk("xor_file_we", 0, wwe);
		chk("phase_idle", tssx_pkg::TSSX_Q1, phase);
		run(16'hffff);
		chk("nop_flags", 2'h1, flags);
		chk("nop_file_we", 0, wwe);
	endtask

	task t_swap;
		file_rdata = 8'h53;
		run({tssx_pkg::OPC_SWAP, 2'b10, 8'h20});
		chk("swap_cycles", 4, ncyc);
		chk("swap_data", 8'h35, fw.data);
		chk("swap_file_we", 1, wwe);
		chk("swap_addr", 8'h20, fa);
		chk("swap_wr_addr", 8'h20, fw.addr);
		chk("swap_wr_bank", 4'h0, fw.bank);
		chk("access_bank", 4'h0, fb);
		chk("swap_flags_we", 0, fwe);
		run({tssx_pkg::OPC_SWAP, 2'b01, 8'h60});
		chk("swap_wreg", 8'h35, wreg);
		chk("swap_file_we", 0, wwe);
		chk("bsr_bank", 4'h5, fb);
		chk("flags_kept", 2'h1, flags);
		run({tssx_pkg::OPC_SWAP, 2'b00, 8'h80});
		chk("sfr_bank", 4'hf, fb);
		ext_set_en = 1'b1;
		run({tssx_pkg::OPC_SWAP, 2'b00, 8'h60});
		chk("indexed_above", 0, fi);
		run({tssx_pkg::OPC_SWAP, 2'b00, 8'h5f});
		chk("indexed", 1, fi);
		run({tssx_pkg::OPC_SWAP, 2'b01, 8'h5f});
		chk("indexed_bsr", 0, fi);
		ext_set_en = 1'b0;
	endtask

	task t_table_read_op;
		logic [1:0] ms [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2};
		for (int i = 0; i < 6; i++) begin
			ea = (ms[i] == 2'h3) ? p + 21'h1 : p;
			p = (ms[i] == 2'h1 || ms[i] == 2'h3) ? p + 21'h1 : (ms[i] == 2'h2) ? p - 21'h1 : p;
			run({12'h000, tssx_pkg::TBL_RD, ms[i]});
			chk("rd_cycles", 8, ncyc);
			chk("latch", pmb(ea), table_latch);
			chk("pointer", p, table_pointer);
		end
	endtask

	task t_table_write_op;
		logic [1:0] ms [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
		logic [7:0] el;
		el = pmb(ea);
		for (int i = 0; i < 4; i++) begin
			ea = (ms[i] == 2'h3) ? p + 21'h1 : p;
			p = (ms[i] == 2'h1 || ms[i] == 2'h3) ? p + 21'h1 : (ms[i] == 2'h2) ? p - 21'h1 : p;
			run({12'h000, tssx_pkg::TBL_WR, ms[i]});
			chk("wt_cycles", 8, ncyc);
			chk("wt_pointer", p, table_pointer);
			chk("hold_addr", ea[6:0], hold_addr);
			hold_raddr = ea[6:0];
			@(negedge sys_clk);
			chk("holding", el, hold_rdata);
			chk("latch_kept", el, table_latch);
		end
	endtask

	task t_skip;
		file_rdata = 8'h01;
		run({tssx_pkg::OPC_TSTSZ, 1'b1, 8'h10});
		chk("noskip_cycles", 4, ncyc);
		chk("noskip_discard", 0, dsc);
		file_rdata = 8'h00;
		for (int i = 1; i < 4; i++) begin
			next_words = i[1:0];
			run({tssx_pkg::OPC_TSTSZ, 1'b0, 8'h70});
			chk("skip_cycles", 4 * (i + 1), ncyc);
			chk("skip_discard", 1, dsc);
		end
		chk("skip_flags", 2'h1, flags);
	endtask

	initial begin
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_xor();
		t_swap();
		t_table_read_op();
		t_table_write_op();
		t_skip();
		wrap_up();
	end
endmodule
`default_nettype wire
